// ### design/ebp_pkg.sv
package ebp_pkg;
    // ********************************
    // Widths and reset values
    // ********************************
    localparam int ADDR_W = 24;
    localparam int IADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int SHORT_W = 16;
    localparam int BANKS = 4;
    localparam int BANK_LSB = 24;
    localparam int SDC_W = 8;
    localparam logic [BANKS-1:0] BANK_IDLE = 4'hF;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;
    localparam logic [DATA_W-1:0] OE_FULL = 32'hFFFFFFFF;
    localparam logic [DATA_W-1:0] OE_SHORT = 32'h0000FFFF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h0;

    // ********************************
    // States
    // ********************************
    typedef enum logic [1:0] {
        EBP_M_IDLE = 2'h0,
        EBP_M_ADDR = 2'h1,
        EBP_M_STRB = 2'h3,
        EBP_M_DONE = 2'h2
    } ebp_mst_t;

    typedef enum logic [1:0] {
        EBP_S_IDLE = 2'h0,
        EBP_S_BUSY = 2'h1,
        EBP_S_ACK = 2'h3,
        EBP_S_SPARE = 2'h2
    } ebp_slv_t;

    typedef struct packed {
        ebp_mst_t mst;
        ebp_slv_t slv;
        logic [ADDR_W-1:0] addr;
        logic [BANKS-1:0] sel_n;
        logic [BANKS-1:0] bank_n;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] doe;
        logic rd_n;
        logic wr_n;
        logic sw_n;
        logic own;
        logic flt;
        logic keep;
        logic write;
        logic short;
        logic cond_ok;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic s_valid;
        logic s_write;
        logic s_host;
        logic [ADDR_W-1:0] s_addr;
        logic [DATA_W-1:0] s_wdata;
        logic ack_o;
        logic ack_oe;
        logic hw_o;
    } ebp_state_t;
endpackage

// ### design/ebp_top.sv
`timescale 1ns/1ps
// Operation
// - Master access drives the 24-bit external address lines.
// - Address lines are inputs while another master reaches our registers.
// - As bus master, drive address to reach the other processor's registers.
// - Full 32-bit words use data bits 31 down to 0.
// - Short 16-bit words use only data bits 15 down to 0.
// - Internal address bits 25:24 decode to four active-low bank selects.
// - Bank selects change in the same cycle as the address.
// - Selects idle without access, but assert for conditional accesses anyway.
// - Selects mapped to synchronous DRAM may assert with no access.
// - Read strobe asserts for external reads and other-processor register reads.
// - Write strobe asserts for external writes and other-processor register writes.
// - Bus master drives the strobes; the non-master takes them as inputs.
// - Early store select asserts with address; write abandoned without strobe.
// - As non-master, early store select decides read or write; for host accesses the write strobe decides.
// - Deasserted acknowledge holds our access uncompleted.
// - Synchronous register access to us gets acknowledge driven low for waits.
// - Keeper holds acknowledge input at its last driven level.
// - Float request floats address, data, selects, strobes next cycle; DRAM pins stay.
// - An access attempted while floated stalls until float request releases.
// - Giving the bus to a host floats the bus but keeps DRAM pins.
// - Host wait line driven only with chip select and host request; low waits.
module ebp_top
    import ebp_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic MASTER,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic REQ_SHORT,
    input wire logic REQ_COND,
    input wire logic REQ_COND_TRUE,
    input wire logic [IADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_RDATA,
    output logic SLV_VALID,
    input wire logic SLV_READY,
    output logic SLV_WRITE,
    output logic [ADDR_W-1:0] SLV_ADDR,
    output logic [DATA_W-1:0] SLV_WDATA,
    input wire logic [DATA_W-1:0] SLV_RDATA,
    input wire logic [BANKS-1:0] SDRAM_BANK_HOLD,
    input wire logic [SDC_W-1:0] SDRAM_CTL_IN,
    output logic [SDC_W-1:0] SDRAM_CTL_OUT,
    input wire logic [ADDR_W-1:0] ADDR_I,
    output logic [ADDR_W-1:0] ADDR_O,
    output logic [ADDR_W-1:0] ADDR_OE,
    input wire logic [DATA_W-1:0] DATA_I,
    output logic [DATA_W-1:0] DATA_O,
    output logic [DATA_W-1:0] DATA_OE,
    output logic [BANKS-1:0] BANK_SELECT_N_O,
    output logic [BANKS-1:0] BANK_SELECT_N_OE,
    input wire logic RD_N_I,
    output logic RD_N_O,
    output logic RD_N_OE,
    input wire logic WR_N_I,
    output logic WR_N_O,
    output logic WR_N_OE,
    input wire logic EARLY_STORE_SELECT_N_I,
    output logic EARLY_STORE_SELECT_N_O,
    output logic EARLY_STORE_SELECT_N_OE,
    input wire logic ACK_I,
    input wire logic ACK_DRIVEN,
    output logic ACK_O,
    output logic ACK_OE,
    input wire logic BUS_FLOAT_REQUEST_N,
    input wire logic HOST_BUS_REQUEST_N,
    input wire logic CHIP_SELECT_N,
    output logic HOST_WAIT_LINE_O,
    output logic HOST_WAIT_LINE_OE
);
    // ********************************
    // Decode
    // ********************************
    function automatic logic [BANKS-1:0] bank_decode(input logic [1:0] hi);
        logic [BANKS-1:0] v;
        v = BANK_IDLE;
        v[hi] = 1'b0;
        return v;
    endfunction

    ebp_state_t r_reg;
    ebp_state_t r_next;
    logic ack_eff;
    logic stall;
    logic accept;
    logic strobe_in;
    logic host_acc;
    logic drive;

    // Keeper: undriven line reads as last driven level
    assign ack_eff = ACK_DRIVEN ? ACK_I : r_reg.keep;
    assign stall = ~BUS_FLOAT_REQUEST_N;
    assign strobe_in = ~RD_N_I | ~WR_N_I;
    assign host_acc = ~CHIP_SELECT_N & ~HOST_BUS_REQUEST_N;
    assign REQ_READY = (r_reg.mst == EBP_M_IDLE) && r_reg.own && MASTER && HOST_BUS_REQUEST_N && !stall;
    assign accept = REQ_VALID & REQ_READY;
    assign drive = r_reg.own & ~r_reg.flt;

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        r_next = r_reg;
        r_next.rsp_valid = 1'b0;
        r_next.keep = ack_eff;
        r_next.flt = ~BUS_FLOAT_REQUEST_N;
        // Finish a running access before yielding to the host
        r_next.own = MASTER & (HOST_BUS_REQUEST_N | (r_reg.mst != EBP_M_IDLE));
        case (r_reg.mst)
            EBP_M_IDLE: begin
                if (accept) begin
                    r_next.addr = REQ_ADDR[ADDR_W-1:0];
                    r_next.sel_n = bank_decode(REQ_ADDR[BANK_LSB+1:BANK_LSB]);
                    r_next.write = REQ_WRITE;
                    r_next.short = REQ_SHORT;
                    r_next.cond_ok = ~REQ_COND | REQ_COND_TRUE;
                    r_next.sw_n = ~REQ_WRITE;
                    r_next.dout = REQ_SHORT ? {16'h0, REQ_WDATA[SHORT_W-1:0]} : REQ_WDATA;
                    r_next.doe = REQ_WRITE ? (REQ_SHORT ? OE_SHORT : OE_FULL) : DATA_ZERO;
                    r_next.mst = EBP_M_ADDR;
                end
            end
            EBP_M_ADDR: begin
                if (!stall) begin
                    if (r_reg.cond_ok) begin
                        r_next.rd_n = r_reg.write;
                        r_next.wr_n = ~r_reg.write;
                        r_next.mst = EBP_M_STRB;
                    end else begin
                        // False condition: select seen, no strobe, write abandoned
                        r_next.sw_n = 1'b1;
                        r_next.rsp_valid = 1'b1;
                        r_next.mst = EBP_M_DONE;
                    end
                end
            end
            EBP_M_STRB: begin
                // Strobe must be back on the pins before acknowledge can end the access
                if (!stall && !r_reg.flt && ack_eff) begin
                    r_next.rd_n = 1'b1;
                    r_next.wr_n = 1'b1;
                    r_next.rsp_valid = 1'b1;
                    if (!r_reg.write) begin
                        r_next.rdata = r_reg.short ? {16'h0, DATA_I[SHORT_W-1:0]} : DATA_I;
                    end
                    r_next.mst = EBP_M_DONE;
                end
            end
            EBP_M_DONE: begin
                r_next.sel_n = BANK_IDLE;
                r_next.sw_n = 1'b1;
                r_next.doe = DATA_ZERO;
                r_next.mst = EBP_M_IDLE;
            end
            default: begin
                r_next.mst = EBP_M_IDLE;
            end
        endcase
        // Slave side: someone else owns the bus
        case (r_reg.slv)
            EBP_S_IDLE: begin
                if (!r_reg.own && strobe_in) begin
                    r_next.s_host = host_acc;
                    r_next.s_write = host_acc ? ~WR_N_I : ~EARLY_STORE_SELECT_N_I;
                    r_next.s_addr = ADDR_I;
                    r_next.s_wdata = DATA_I;
                    r_next.s_valid = 1'b1;
                    r_next.ack_oe = ~host_acc;
                    r_next.ack_o = 1'b0;
                    r_next.hw_o = ~host_acc;
                    r_next.slv = EBP_S_BUSY;
                end
            end
            EBP_S_BUSY: begin
                if (SLV_READY) begin
                    r_next.s_valid = 1'b0;
                    r_next.ack_o = 1'b1;
                    r_next.hw_o = 1'b1;
                    if (!r_reg.s_write) begin
                        r_next.dout = SLV_RDATA;
                        r_next.doe = OE_FULL;
                    end
                    r_next.slv = EBP_S_ACK;
                end
            end
            EBP_S_ACK: begin
                if (!strobe_in) begin
                    r_next.doe = DATA_ZERO;
                    r_next.ack_oe = 1'b0;
                    r_next.slv = EBP_S_IDLE;
                end
            end
            default: begin
                r_next.slv = EBP_S_IDLE;
            end
        endcase
        // Controller may hold a DRAM bank select with no access running
        r_next.bank_n = r_next.sel_n & ~SDRAM_BANK_HOLD;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            r_reg <= '{mst: EBP_M_IDLE, slv: EBP_S_IDLE, addr: ADDR_ZERO, sel_n: BANK_IDLE,
                bank_n: BANK_IDLE, dout: DATA_ZERO, doe: DATA_ZERO, rd_n: 1'b1, wr_n: 1'b1,
                sw_n: 1'b1, own: 1'b0, flt: 1'b0, keep: 1'b1, write: 1'b0, short: 1'b0,
                cond_ok: 1'b0, rsp_valid: 1'b0, rdata: DATA_ZERO, s_valid: 1'b0,
                s_write: 1'b0, s_host: 1'b0, s_addr: ADDR_ZERO, s_wdata: DATA_ZERO,
                ack_o: 1'b1, ack_oe: 1'b0, hw_o: 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end

    // ********************************
    // Pins
    // ********************************
    assign ADDR_O = r_reg.addr;
    assign ADDR_OE = {ADDR_W{drive}};
    assign DATA_O = r_reg.dout;
    assign DATA_OE = r_reg.doe & {DATA_W{~r_reg.flt}};
    assign BANK_SELECT_N_O = r_reg.bank_n;
    assign BANK_SELECT_N_OE = {BANKS{drive}};
    assign RD_N_O = r_reg.rd_n;
    assign RD_N_OE = drive;
    assign WR_N_O = r_reg.wr_n;
    assign WR_N_OE = drive;
    assign EARLY_STORE_SELECT_N_O = r_reg.sw_n;
    assign EARLY_STORE_SELECT_N_OE = drive;
    assign ACK_O = r_reg.ack_o;
    assign ACK_OE = r_reg.ack_oe & ~r_reg.own;
    // DRAM control is never floated
    assign SDRAM_CTL_OUT = SDRAM_CTL_IN;
    assign HOST_WAIT_LINE_O = r_reg.hw_o;
    assign HOST_WAIT_LINE_OE = host_acc;
    assign RSP_VALID = r_reg.rsp_valid;
    assign RSP_RDATA = r_reg.rdata;
    assign SLV_VALID = r_reg.s_valid;
    assign SLV_WRITE = r_reg.s_write;
    assign SLV_ADDR = r_reg.s_addr;
    assign SLV_WDATA = r_reg.s_wdata;

    // ********************************
    // Checks
    // ********************************
    property p_bank_decode;
        @(posedge CLK_SYS) disable iff (RST)
        accept |=> r_reg.sel_n == bank_decode($past(REQ_ADDR[BANK_LSB+1:BANK_LSB]));
    endproperty
    a_bank_decode: assert property (p_bank_decode) else $error("bank select decode wrong");

    property p_bank_idle;
        @(posedge CLK_SYS) disable iff (RST)
        (r_reg.mst == EBP_M_IDLE) |-> (r_reg.sel_n == BANK_IDLE);
    endproperty
    a_bank_idle: assert property (p_bank_idle) else $error("bank select active while idle");

    property p_early_store;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && REQ_WRITE) |=> (!EARLY_STORE_SELECT_N_O && ADDR_O == $past(REQ_ADDR[ADDR_W-1:0]));
    endproperty
    a_early_store: assert property (p_early_store) else $error("early store select not with address");

    property p_read_strobe;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && !REQ_WRITE && (!REQ_COND || REQ_COND_TRUE)) ##1 BUS_FLOAT_REQUEST_N |=> !RD_N_O && WR_N_O;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing");

    property p_float;
        @(posedge CLK_SYS) disable iff (RST)
        !BUS_FLOAT_REQUEST_N |=> (ADDR_OE == ADDR_ZERO) && (DATA_OE == DATA_ZERO) && !RD_N_OE;
    endproperty
    a_float: assert property (p_float) else $error("bus not floated after float request");

    property p_stall;
        @(posedge CLK_SYS) disable iff (RST)
        (r_reg.mst == EBP_M_STRB && stall) |=> (r_reg.mst == EBP_M_STRB) && !RSP_VALID;
    endproperty
    a_stall: assert property (p_stall) else $error("access finished while floated");

    property p_wait;
        @(posedge CLK_SYS) disable iff (RST)
        (r_reg.mst == EBP_M_STRB && !ack_eff) |=> !RSP_VALID && (r_reg.mst == EBP_M_STRB);
    endproperty
    a_wait: assert property (p_wait) else $error("access done without acknowledge");

    property p_complete;
        @(posedge CLK_SYS) disable iff (RST)
        (r_reg.mst == EBP_M_STRB && ack_eff && !stall && !r_reg.flt) |=> RSP_VALID && RD_N_O && WR_N_O;
    endproperty
    a_complete: assert property (p_complete) else $error("acknowledged access not completed");

    property p_slave_ack;
        @(posedge CLK_SYS) disable iff (RST)
        (r_reg.slv == EBP_S_IDLE && !r_reg.own && !MASTER && strobe_in && !host_acc) |=> ACK_OE && !ACK_O;
    endproperty
    a_slave_ack: assert property (p_slave_ack) else $error("slave did not pull acknowledge low");

    property p_addr_input;
        @(posedge CLK_SYS) disable iff (RST)
        (r_reg.slv != EBP_S_IDLE) |-> (ADDR_OE == ADDR_ZERO);
    endproperty
    a_addr_input: assert property (p_addr_input) else $error("address driven during slave access");
endmodule

// ### verification/ebp_mem_model.sv
`timescale 1ns/1ps
// ********
// Memory bank on the far side of the bus
// ********
module ebp_mem_model
    import ebp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] waits,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic strobe_oe,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata,
    output logic ack,
    output logic ack_driven
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last;
    logic [3:0] cnt;
    logic active;

    assign active = strobe_oe && !(rd_n && wr_n);
    // Undriven outside strobes, keeper holds the last level
    assign ack_driven = active;
    assign ack = active && cnt >= waits;
    // Released bus shows inverse of last value so stale data never passes
    assign rdata = (active && !rd_n) ? mem[addr[3:0]] : ~last;

    always @(posedge clk) begin
        if (rst) begin
            cnt <= 4'h0;
            last <= DATA_ZERO;
        end else begin
            cnt <= active ? cnt + 4'h1 : 4'h0;
            if (active && !rd_n) begin
                last <= mem[addr[3:0]];
            end
            if (active && !wr_n && ack) begin
                mem[addr[3:0]] <= wdata;
            end
        end
    end
endmodule

// ### verification/external_bus_port_test.sv
`timescale 1ns/1ps
module external_bus_port_test
    import ebp_pkg::*;
;
    // ********
    // Pins and partner
    // ********
    localparam logic hi = 1'h1;
    localparam logic lo = 1'h0;
    logic CLK_SYS = 1'h0, RST = 1'h1, MASTER = 1'h1, REQ_VALID = 1'h0, REQ_WRITE = 1'h0, REQ_SHORT = 1'h0;
    logic REQ_COND = 1'h0, REQ_COND_TRUE = 1'h0, SLV_READY = 1'h0, CHIP_SELECT_N = 1'h1, HOST_BUS_REQUEST_N = 1'h1;
    logic BUS_FLOAT_REQUEST_N = 1'h1, s_rd_n = 1'h1, s_wr_n = 1'h1, s_sw_n = 1'h1, m_ack, m_drv;
    logic REQ_READY, RSP_VALID, SLV_VALID, SLV_WRITE, RD_N_O, RD_N_OE, WR_N_O, WR_N_OE, ACK_O, ACK_OE;
    logic EARLY_STORE_SELECT_N_O, EARLY_STORE_SELECT_N_OE, HOST_WAIT_LINE_O, HOST_WAIT_LINE_OE;
    logic [IADDR_W-1:0] REQ_ADDR = 26'h0;
    logic [DATA_W-1:0] REQ_WDATA = 32'h0, SLV_RDATA = 32'h0, s_data = 32'h0, RSP_RDATA, SLV_WDATA, DATA_O, DATA_OE, m_data;
    logic [ADDR_W-1:0] s_addr = 24'h0, SLV_ADDR, ADDR_O, ADDR_OE;
    logic [BANKS-1:0] SDRAM_BANK_HOLD = 4'h0, BANK_SELECT_N_O, BANK_SELECT_N_OE;
    logic [SDC_W-1:0] SDRAM_CTL_IN = 8'h5A, SDRAM_CTL_OUT;
    logic [3:0] waits = 4'h0;
    wire logic [DATA_W-1:0] DATA_I;
    wire logic [ADDR_W-1:0] ADDR_I;
    wire logic RD_N_I, WR_N_I, EARLY_STORE_SELECT_N_I, ACK_I, ACK_DRIVEN;
    int failures = 0;
    int samples_checked = 0;

    // Each wire carries whichever party has its enable up
    assign DATA_I = (DATA_O & DATA_OE) | ((MASTER ? m_data : s_data) & ~DATA_OE);
    assign ADDR_I = (ADDR_O & ADDR_OE) | (s_addr & ~ADDR_OE);
    assign RD_N_I = RD_N_OE ? RD_N_O : s_rd_n;
    assign WR_N_I = WR_N_OE ? WR_N_O : s_wr_n;
    assign EARLY_STORE_SELECT_N_I = EARLY_STORE_SELECT_N_OE ? EARLY_STORE_SELECT_N_O : s_sw_n;
    assign ACK_I = ACK_OE ? ACK_O : m_ack;
    assign ACK_DRIVEN = ACK_OE | m_drv;

    ebp_top i_ebp_top(.CLK_SYS(CLK_SYS), .RST(RST), .MASTER(MASTER), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
        .REQ_WRITE(REQ_WRITE), .REQ_SHORT(REQ_SHORT), .REQ_COND(REQ_COND), .REQ_COND_TRUE(REQ_COND_TRUE),
        .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
        .SLV_VALID(SLV_VALID), .SLV_READY(SLV_READY), .SLV_WRITE(SLV_WRITE), .SLV_ADDR(SLV_ADDR),
        .SLV_WDATA(SLV_WDATA), .SLV_RDATA(SLV_RDATA), .SDRAM_BANK_HOLD(SDRAM_BANK_HOLD),
        .SDRAM_CTL_IN(SDRAM_CTL_IN), .SDRAM_CTL_OUT(SDRAM_CTL_OUT), .ADDR_I(ADDR_I), .ADDR_O(ADDR_O),
        .ADDR_OE(ADDR_OE), .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE(DATA_OE), .BANK_SELECT_N_O(BANK_SELECT_N_O),
        .BANK_SELECT_N_OE(BANK_SELECT_N_OE), .RD_N_I(RD_N_I), .RD_N_O(RD_N_O), .RD_N_OE(RD_N_OE), .WR_N_I(WR_N_I),
        .WR_N_O(WR_N_O), .WR_N_OE(WR_N_OE), .EARLY_STORE_SELECT_N_I(EARLY_STORE_SELECT_N_I),
        .EARLY_STORE_SELECT_N_O(EARLY_STORE_SELECT_N_O), .EARLY_STORE_SELECT_N_OE(EARLY_STORE_SELECT_N_OE),
        .ACK_I(ACK_I), .ACK_DRIVEN(ACK_DRIVEN), .ACK_O(ACK_O), .ACK_OE(ACK_OE),
        .BUS_FLOAT_REQUEST_N(BUS_FLOAT_REQUEST_N), .HOST_BUS_REQUEST_N(HOST_BUS_REQUEST_N),
        .CHIP_SELECT_N(CHIP_SELECT_N), .HOST_WAIT_LINE_O(HOST_WAIT_LINE_O), .HOST_WAIT_LINE_OE(HOST_WAIT_LINE_OE));
    ebp_mem_model i_ebp_mem_model(.clk(CLK_SYS), .rst(RST), .waits(waits), .addr(ADDR_O), .rd_n(RD_N_O),
        .wr_n(WR_N_O), .strobe_oe(RD_N_OE), .wdata(DATA_O & DATA_OE), .rdata(m_data), .ack(m_ack),
        .ack_driven(m_drv));

    always #2.5 CLK_SYS = ~CLK_SYS;

    // ********
    // Scenarios
    // ********
    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic access(input logic wr, sh, cnd, ct, input logic [IADDR_W-1:0] a,
        input logic [DATA_W-1:0] wd, exp, input int w, fl);
        int n;
        logic go;
        logic [BANKS-1:0] sel;
        n = 0;
        go = !cnd || ct;
        sel = ~(4'h1 << a[25:24]);
        @(posedge CLK_SYS);
        waits <= w[3:0];
        REQ_VALID <= hi;
        REQ_WRITE <= wr;
        REQ_SHORT <= sh;
        REQ_COND <= cnd;
        REQ_COND_TRUE <= ct;
        REQ_ADDR <= a;
        REQ_WDATA <= wd;
        do @(negedge CLK_SYS); while (!REQ_READY);
        @(posedge CLK_SYS);
        REQ_VALID <= lo;
        do begin
            @(negedge CLK_SYS);
            n++;
            if (n == 1) chk("early store select", !wr, EARLY_STORE_SELECT_N_O);
            if (n == 1 && fl > 0) begin
                @(posedge CLK_SYS);
                BUS_FLOAT_REQUEST_N <= lo;
            end
            if (n == 2) begin
                chk("address", a[ADDR_W-1:0], ADDR_O);
                chk("bank select", sel, BANK_SELECT_N_O);
                chk("early store select", !(wr && go), EARLY_STORE_SELECT_N_O);
            end
            if (n == 2 && fl == 0) begin
                chk("read strobe", !(go && !wr), RD_N_O);
                chk("write strobe", !(go && wr), WR_N_O);
                if (go) chk("data enable", wr ? (sh ? OE_SHORT : OE_FULL) : DATA_ZERO, DATA_OE);
            end
            if (n == 4 && fl > 0) begin
                chk("floated enables", 32'h0, {ADDR_OE, BANK_SELECT_N_OE, RD_N_OE, WR_N_OE});
                chk("floated data", 32'h0, DATA_OE);
                chk("dram pins", SDRAM_CTL_IN, SDRAM_CTL_OUT);
            end
            if (n == 2 + fl && fl > 0) begin
                @(posedge CLK_SYS);
                BUS_FLOAT_REQUEST_N <= hi;
            end
        end while (!RSP_VALID && n < 40);
        if (fl == 0) chk("latency", go ? 3 + w : 2, n);
        else chk("stalled", 1'h1, n > 2 + fl);
        if (!wr && go) chk("read data", exp, RSP_RDATA);
        @(negedge CLK_SYS);
        chk("idle select", BANK_IDLE, BANK_SELECT_N_O);
    endtask

    task automatic host_check();
        @(posedge CLK_SYS);
        HOST_BUS_REQUEST_N <= lo;
        SDRAM_BANK_HOLD <= 4'h4;
        SDRAM_CTL_IN <= 8'hC3;
        repeat (3) @(negedge CLK_SYS);
        chk("ready while yielded", 1'h0, REQ_READY);
        chk("yielded enables", 32'h0, {ADDR_OE, BANK_SELECT_N_OE, RD_N_OE, WR_N_OE, EARLY_STORE_SELECT_N_OE});
        chk("dram pins", SDRAM_CTL_IN, SDRAM_CTL_OUT);
        chk("host wait enable", 1'h0, HOST_WAIT_LINE_OE);
        @(posedge CLK_SYS);
        CHIP_SELECT_N <= lo;
        s_addr <= 24'h000123;
        s_wr_n <= lo;
        @(negedge CLK_SYS);
        chk("host wait enable", 1'h1, HOST_WAIT_LINE_OE);
        chk("host wait idle", 1'h1, HOST_WAIT_LINE_O);
        @(negedge CLK_SYS);
        chk("host access", 4'h3, {HOST_WAIT_LINE_O, ACK_OE, SLV_VALID, SLV_WRITE});
        chk("host address", 24'h000123, SLV_ADDR);
        @(posedge CLK_SYS);
        SLV_READY <= hi;
        @(posedge CLK_SYS);
        SLV_READY <= lo;
        @(negedge CLK_SYS);
        chk("host wait done", 1'h1, HOST_WAIT_LINE_O);
        @(posedge CLK_SYS);
        HOST_BUS_REQUEST_N <= hi;
        CHIP_SELECT_N <= hi;
        s_wr_n <= hi;
        repeat (3) @(negedge CLK_SYS);
        chk("dram bank hold", 4'hB, BANK_SELECT_N_O);
        chk("no response", 1'h0, RSP_VALID);
        @(posedge CLK_SYS);
        SDRAM_BANK_HOLD <= 4'h0;
    endtask

    task automatic slave(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        s_addr <= a;
        s_data <= d;
        s_sw_n <= !wr;
        s_rd_n <= wr;
        s_wr_n <= !wr;
        do begin
            @(negedge CLK_SYS);
            n++;
        end while (!SLV_VALID && n < 8);
        chk("slave address", a, SLV_ADDR);
        chk("address input", 24'h0, ADDR_OE);
        chk("strobes input", 2'h0, {RD_N_OE, WR_N_OE});
        chk("slave direction", wr, SLV_WRITE);
        if (wr) chk("slave data", d, SLV_WDATA);
        repeat (2) @(negedge CLK_SYS);
        chk("ack wait", 2'h2, {ACK_OE, ACK_O});
        @(posedge CLK_SYS);
        SLV_READY <= hi;
        SLV_RDATA <= ~d;
        @(posedge CLK_SYS);
        SLV_READY <= lo;
        repeat (2) @(negedge CLK_SYS);
        chk("ack done", 2'h3, {ACK_OE, ACK_O});
        if (!wr) chk("slave read data", ~d, DATA_O & DATA_OE);
        @(posedge CLK_SYS);
        s_rd_n <= hi;
        s_wr_n <= hi;
        s_sw_n <= hi;
        s_data <= ~d;
        repeat (3) @(negedge CLK_SYS);
        chk("slave released", 32'h0, DATA_OE | ACK_OE);
    endtask

    initial begin
        repeat (16) @(posedge CLK_SYS);
        chk("reset enables", 32'h0, {ADDR_OE, RD_N_OE, WR_N_OE});
        chk("reset outputs", 4'hF, {RD_N_O, WR_N_O, ACK_O, ~RSP_VALID});
        RST <= lo;
        for (int b = 0; b < 4; b++) begin
            access(hi, lo, lo, lo, {b[1:0], 20'h5A5A5, 2'h0, b[1:0]}, {28'hA5C30F0, b[3:0]}, 32'h0, b, 0);
        end
        for (int b = 0; b < 4; b++) begin
            access(lo, lo, lo, lo, {b[1:0], 20'h5A5A5, 2'h0, b[1:0]}, 32'h0, {28'hA5C30F0, b[3:0]}, 3 - b, 0);
        end
        access(lo, hi, lo, lo, 26'h1000001, 32'h0, 32'h00000F01, 1, 0);
        access(hi, hi, lo, lo, 26'h200000F, 32'h89AB1357, 32'h0, 0, 0);
        access(hi, lo, hi, hi, 26'h100000E, 32'h600DF00D, 32'h0, 2, 0);
        access(hi, lo, hi, lo, 26'h300000E, 32'h12345678, 32'h0, 0, 0);
        access(lo, lo, hi, lo, 26'h000000E, 32'h0, 32'h0, 0, 0);
        access(lo, lo, lo, lo, 26'h200000E, 32'h0, 32'h600DF00D, 0, 0);
        access(lo, lo, lo, lo, 26'h2000002, 32'h0, 32'hA5C30F02, 0, 4);
        host_check();
        @(posedge CLK_SYS);
        MASTER <= lo;
        repeat (3) @(posedge CLK_SYS);
        slave(hi, 24'h00A5C3, 32'h13579BDF);
        slave(lo, 24'hF00001, 32'h2468ACE0);
        close_out();
    end

    // Span far above the roughly 150 cycles the scenarios need
    initial begin
        repeat (5000) @(posedge CLK_SYS);
        failures++;
        close_out();
    end
endmodule
